// ### logic/pfsp_regs.vh
`ifndef PFSP_REGS_VH
`define PFSP_REGS_VH
// software register offsets
`define PFSP_CTRL_OFS 8'h00
`define PFSP_ADDR_OFS 8'h04
`define PFSP_DATA_OFS 8'h08
`define PFSP_STAT_OFS 8'h0C
`define PFSP_IRQS_OFS 8'h10
`define PFSP_IRQM_OFS 8'h14
// control field positions
`define PFSP_CTRL_START 0
`define PFSP_CTRL_OP_LO 1
`define PFSP_CTRL_TOGGLE 3
`define PFSP_CTRL_UNPROT 4
// status field positions
`define PFSP_STAT_BUSY 0
`define PFSP_STAT_FAIL 1
`define PFSP_STAT_PROT 2
`define PFSP_STAT_LAST_LO 8
// interrupt bits
`define PFSP_IRQ_DONE 0
`define PFSP_IRQ_FAIL 1
// reset values
`define PFSP_CTRL_RST 5'h00
`define PFSP_IRQM_RST 2'h0
// operation codes
`define PFSP_OP_PROG 2'h0
`define PFSP_OP_CHIP 2'h1
`define PFSP_OP_SECT 2'h2
`define PFSP_OP_VRFY 2'h3
// command sequence words
`define PFSP_UNLK_A1 16'h0555
`define PFSP_UNLK_A2 16'h02AA
`define PFSP_D_AA 8'hAA
`define PFSP_D_55 8'h55
`define PFSP_D_PROG 8'hA0
`define PFSP_D_ERASE 8'h80
`define PFSP_D_CHIP 8'h10
`define PFSP_D_SECT 8'h30
`define PFSP_D_VRFY 8'h90
`define PFSP_D_RESET 8'hF0
`define PFSP_VRFY_OFS 16'h0002
// status bit positions on the data pins
`define PFSP_DATA_POLL_BIT 7
`define PFSP_TOGGLE_STATUS_BIT 6
`define PFSP_TIME_LIMIT_FLAG 5
// timing
`define PFSP_CLK_NS 100
`define PFSP_RD_NS 400
`define PFSP_RD_CYC ((`PFSP_RD_NS + `PFSP_CLK_NS - 1) / `PFSP_CLK_NS)
`endif

// ### logic/pfsp_host.v
// Function
// - limit flag seen: reread poll bit first
// - poll target, sector, or any address
// - limit flag seen: resample toggle bit
// - erase needs six write cycles
`timescale 1ns/1ps
`default_nettype none
`include "pfsp_regs.vh"

module pfsp_host #(
  parameter AW = 19
) (
  input wire mclk,
  input wire nrst,
  input wire [7:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_we,
  input wire reg_re,
  output reg [31:0] reg_rdata,
  output reg irq,
  output reg [AW-1:0] flash_addr,
  output reg [7:0] flash_dq_o,
  output reg flash_dq_oe,
  input wire [7:0] flash_dq_i,
  output reg flash_ce_n,
  output reg flash_oe_n,
  output reg flash_we_n,
  output reg flash_unprot
);

  ////////////////////////////////////////////////////////////////////////
  // states
  localparam [2:0] S_IDLE = 3'd0;
  localparam [2:0] S_WSET = 3'd1;
  localparam [2:0] S_WLOW = 3'd2;
  localparam [2:0] S_WEND = 3'd3;
  localparam [2:0] S_RD = 3'd4;
  localparam [2:0] S_REND = 3'd5;
  localparam [2:0] STEP_RESET = 3'd7;
  localparam integer RD_NUM = `PFSP_RD_CYC; // read access clocks
  localparam [3:0] RD_CYC = RD_NUM[3:0];

  // software state
  reg [1:0] op_q; // selected operation
  reg tog_q; // toggle method instead of data poll
  reg [AW-1:0] tgt_q; // target or sector address
  reg [7:0] pd_q; // program value
  reg busy_q; // sequence running
  reg fail_q; // last operation failed
  reg prot_q; // last verify result
  reg [7:0] last_q; // last value read from flash
  reg [1:0] irqs_q; // sticky events
  reg [1:0] irqm_q; // event mask
  // sequencer state
  reg [2:0] st_q; // bus state
  reg [2:0] step_q; // command cycle index
  reg [3:0] cnt_q; // read access counter
  reg polling_q; // reads are status polls
  reg recheck_q; // limit flag already seen
  reg have_first_q; // toggle: first read held
  reg [7:0] first_q; // toggle: previous read
  // pin synchroniser
  reg [7:0] dq_s1_q;
  reg [7:0] dq_s2_q;
  // event pulses
  reg ev_done;
  reg ev_fail;
  wire [AW-1:0] a1 = {{(AW-16){1'b0}}, `PFSP_UNLK_A1};
  wire [AW-1:0] a2 = {{(AW-16){1'b0}}, `PFSP_UNLK_A2};
  // verify readout offset, widened to the address bus
  wire [AW-1:0] vofs = {{(AW-16){1'b0}}, `PFSP_VRFY_OFS};

  ////////////////////////////////////////////////////////////////////////
  // command sequence tables
  function [2:0] seq_len;
    input [1:0] op;
    begin
      case (op)
        `PFSP_OP_PROG: seq_len = 3'd4;
        `PFSP_OP_VRFY: seq_len = 3'd3;
        default: seq_len = 3'd6;
      endcase
    end
  endfunction

  // address for one command cycle
  function [AW-1:0] seq_addr;
    input [1:0] op;
    input [2:0] step;
    input [AW-1:0] tgt;
    begin
      case (step)
        3'd1: seq_addr = a2;
        3'd4: seq_addr = a2;
        3'd3: seq_addr = (op == `PFSP_OP_PROG) ? tgt : a1;
        3'd5: seq_addr = (op == `PFSP_OP_SECT) ? tgt : a1;
        default: seq_addr = a1;
      endcase
    end
  endfunction

  // data for one command cycle
  function [7:0] seq_data;
    input [1:0] op;
    input [2:0] step;
    input [7:0] pd;
    begin
      case (step)
        3'd0: seq_data = `PFSP_D_AA;
        3'd1: seq_data = `PFSP_D_55;
        3'd2: begin
          if (op == `PFSP_OP_PROG)
            seq_data = `PFSP_D_PROG;
          else if (op == `PFSP_OP_VRFY)
            seq_data = `PFSP_D_VRFY;
          else
            seq_data = `PFSP_D_ERASE;
        end
        3'd3: seq_data = (op == `PFSP_OP_PROG) ? pd : `PFSP_D_AA;
        3'd4: seq_data = `PFSP_D_55;
        3'd5: begin
          seq_data = (op == `PFSP_OP_SECT) ? `PFSP_D_SECT : `PFSP_D_CHIP;
        end
        default: seq_data = `PFSP_D_RESET;
      endcase
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // two-stage synchroniser on the data pins
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      dq_s1_q <= 8'h00;
      dq_s2_q <= 8'h00;
    end else begin
      dq_s1_q <= flash_dq_i;
      dq_s2_q <= dq_s1_q;
    end
  end

  // value read this cycle and expected final poll bit
  wire [7:0] rd = dq_s2_q;
  wire exp7 = (op_q == `PFSP_OP_PROG) ? pd_q[7] : 1'b1;
  wire start = reg_we && (reg_addr == `PFSP_CTRL_OFS) &&
               reg_wdata[`PFSP_CTRL_START] && !busy_q;

  ////////////////////////////////////////////////////////////////////////
  // flash bus sequencer
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      st_q <= S_IDLE;
      step_q <= 3'd0;
      cnt_q <= 4'd0;
      polling_q <= 1'b0;
      recheck_q <= 1'b0;
      have_first_q <= 1'b0;
      first_q <= 8'h00;
      busy_q <= 1'b0;
      fail_q <= 1'b0;
      prot_q <= 1'b0;
      last_q <= 8'h00;
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      flash_addr <= {AW{1'b0}};
      flash_dq_o <= 8'h00;
      flash_dq_oe <= 1'b0;
      flash_ce_n <= 1'b1;
      flash_oe_n <= 1'b1;
      flash_we_n <= 1'b1;
    end else begin
      ev_done <= 1'b0;
      ev_fail <= 1'b0;
      case (st_q)
        S_IDLE: begin
          // start a new command sequence
          if (start) begin
            busy_q <= 1'b1;
            fail_q <= 1'b0;
            step_q <= 3'd0;
            recheck_q <= 1'b0;
            have_first_q <= 1'b0;
            st_q <= S_WSET;
          end
        end
        S_WSET: begin
          // address and data set up, chip selected
          flash_addr <= seq_addr(op_q, step_q, tgt_q);
          flash_dq_o <= seq_data(op_q, step_q, pd_q);
          flash_dq_oe <= 1'b1;
          flash_ce_n <= 1'b0;
          st_q <= S_WLOW;
        end
        S_WLOW: begin
          // write strobe low one period
          flash_we_n <= 1'b0;
          st_q <= S_WEND;
        end
        S_WEND: begin
          // strobe rises, command taken on this edge
          flash_we_n <= 1'b1;
          flash_ce_n <= 1'b1;
          if (step_q == STEP_RESET) begin
            // release the data pins while idle
            flash_dq_oe <= 1'b0;
            busy_q <= 1'b0;
            ev_done <= 1'b1;
            st_q <= S_IDLE;
          end else if (step_q + 3'd1 == seq_len(op_q)) begin
            flash_addr <= (op_q == `PFSP_OP_VRFY) ?
                          (tgt_q | vofs) : tgt_q;
            polling_q <= (op_q != `PFSP_OP_VRFY);
            cnt_q <= 4'd0;
            st_q <= S_RD;
          end else begin
            step_q <= step_q + 3'd1;
            st_q <= S_WSET;
          end
        end
        S_RD: begin
          // output enable held for the access clocks plus one, five clocks in all
          flash_dq_oe <= 1'b0;
          flash_ce_n <= 1'b0;
          flash_oe_n <= 1'b0;
          cnt_q <= cnt_q + 4'd1;
          if (cnt_q == RD_CYC)
            st_q <= S_REND;
        end
        S_REND: begin
          // release bus; each read is a fresh output edge
          flash_ce_n <= 1'b1;
          flash_oe_n <= 1'b1;
          last_q <= rd;
          cnt_q <= 4'd0;
          st_q <= S_RD;
          if (!polling_q) begin
            prot_q <= (rd == 8'h01);
            step_q <= STEP_RESET;
            st_q <= S_WSET;
          end else if (!tog_q) begin
            // poll bit matches only when finished
            if (rd[`PFSP_DATA_POLL_BIT] == exp7) begin
              busy_q <= 1'b0;
              ev_done <= 1'b1;
              st_q <= S_IDLE;
            end else if (recheck_q) begin
              busy_q <= 1'b0;
              fail_q <= 1'b1;
              ev_done <= 1'b1;
              ev_fail <= 1'b1;
              st_q <= S_IDLE;
            end else if (rd[`PFSP_TIME_LIMIT_FLAG]) begin
              recheck_q <= 1'b1;
            end
          end else if (!have_first_q) begin
            // need two reads to see toggling
            first_q <= rd;
            have_first_q <= 1'b1;
          end else if (rd[`PFSP_TOGGLE_STATUS_BIT] ==
                       first_q[`PFSP_TOGGLE_STATUS_BIT]) begin
            // toggling stopped, operation ended
            busy_q <= 1'b0;
            ev_done <= 1'b1;
            st_q <= S_IDLE;
          end else if (recheck_q) begin
            busy_q <= 1'b0;
            fail_q <= 1'b1;
            ev_done <= 1'b1;
            ev_fail <= 1'b1;
            st_q <= S_IDLE;
          end else if (rd[`PFSP_TIME_LIMIT_FLAG]) begin
            recheck_q <= 1'b1;
            have_first_q <= 1'b0;
          end else begin
            first_q <= rd;
          end
        end
        default: st_q <= S_IDLE;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // software registers, sticky events with set over clear
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      op_q <= `PFSP_OP_PROG;
      tog_q <= 1'b0;
      flash_unprot <= 1'b0;
      tgt_q <= {AW{1'b0}};
      pd_q <= 8'h00;
      irqs_q <= 2'h0;
      irqm_q <= `PFSP_IRQM_RST;
      irq <= 1'b0;
    end else begin
      if (reg_we && reg_addr == `PFSP_CTRL_OFS) begin
        // op and method only change while idle
        if (!busy_q) begin
          op_q <= reg_wdata[`PFSP_CTRL_OP_LO+1:`PFSP_CTRL_OP_LO];
          tog_q <= reg_wdata[`PFSP_CTRL_TOGGLE];
        end
        flash_unprot <= reg_wdata[`PFSP_CTRL_UNPROT];
      end
      if (reg_we && reg_addr == `PFSP_ADDR_OFS && !busy_q)
        tgt_q <= reg_wdata[AW-1:0];
      if (reg_we && reg_addr == `PFSP_DATA_OFS && !busy_q)
        pd_q <= reg_wdata[7:0];
      if (reg_we && reg_addr == `PFSP_IRQM_OFS)
        irqm_q <= reg_wdata[1:0];
      irqs_q <= (irqs_q & ~((reg_we && reg_addr == `PFSP_IRQS_OFS) ?
                 reg_wdata[1:0] : 2'h0)) | {ev_fail, ev_done};
      irq <= |(irqs_q & irqm_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // read data, one cycle after the strobe; unmapped reads zero
  always @(posedge mclk or negedge nrst) begin
    if (!nrst) begin
      reg_rdata <= 32'h0000_0000;
    end else if (reg_re) begin
      case (reg_addr)
        `PFSP_CTRL_OFS: reg_rdata <= {27'h000_0000, flash_unprot, tog_q,
                                      op_q, 1'b0};
        `PFSP_ADDR_OFS: reg_rdata <= {{(32-AW){1'b0}}, tgt_q};
        `PFSP_DATA_OFS: reg_rdata <= {24'h00_0000, pd_q};
        `PFSP_STAT_OFS: reg_rdata <= {16'h0000, last_q, 5'h00, prot_q,
                                      fail_q, busy_q};
        `PFSP_IRQS_OFS: reg_rdata <= {30'h0000_0000, irqs_q};
        `PFSP_IRQM_OFS: reg_rdata <= {30'h0000_0000, irqm_q};
        default: reg_rdata <= 32'h0000_0000;
      endcase
    end else begin
      reg_rdata <= 32'h0000_0000;
    end
  end

endmodule // pfsp_host
`default_nettype wire

// ### dv/pfsp_chk_sva.sv
`timescale 1ns/1ps
`default_nettype none
// flash link and register port checks
module pfsp_chk #(
  parameter AW = 19
) (
  input wire logic mclk,
  input wire logic nrst,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_we,
  input wire logic reg_re,
  input wire logic [31:0] reg_rdata,
  input wire logic irq,
  input wire logic [AW-1:0] flash_addr,
  input wire logic [7:0] flash_dq_o,
  input wire logic flash_dq_oe,
  input wire logic flash_ce_n,
  input wire logic flash_oe_n,
  input wire logic flash_we_n
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!nrst);
  // five enabled read clocks then release
  sequence s_rd;
    !flash_oe_n [*5] ##1 flash_oe_n;
  endsequence
  a_we_one: assert property ($fell(flash_we_n) |=> flash_we_n)
    else $error("write strobe not one clock");
  a_we_frame: assert property (!flash_we_n |->
    !flash_ce_n && flash_dq_oe && flash_oe_n)
    else $error("write strobe outside write frame");
  a_wr_hold: assert property ($fell(flash_we_n) |->
    $stable(flash_addr) && $stable(flash_dq_o))
    else $error("write address or data moved");
  a_rd_len: assert property ($fell(flash_oe_n) |-> s_rd)
    else $error("read cycle length wrong");
  a_rd_hold: assert property (!flash_oe_n |=>
    flash_oe_n || $stable(flash_addr))
    else $error("poll address moved in read");
  a_rd_float: assert property (!flash_oe_n |-> !flash_dq_oe)
    else $error("data pins driven during read");
  a_irq_off: assert property (reg_we && reg_addr == 8'h14 &&
    reg_wdata[1:0] == 2'h0 |-> ##2 !irq)
    else $error("irq high with all masked");
  a_rdata_idle: assert property (!$past(reg_re) |-> reg_rdata == 32'h0)
    else $error("read data outside answer cycle");
endmodule // pfsp_chk
bind pfsp_host pfsp_chk #(.AW(AW)) u_chk (.mclk(mclk), .nrst(nrst),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
  .reg_re(reg_re), .reg_rdata(reg_rdata), .irq(irq),
  .flash_addr(flash_addr), .flash_dq_o(flash_dq_o),
  .flash_dq_oe(flash_dq_oe), .flash_ce_n(flash_ce_n),
  .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n));
`default_nettype wire

// ### dv/pfsp_flash_mdl.sv
`timescale 1ns/1ps
`default_nettype none
// behavioural parallel flash, byte mode
module pfsp_flash_mdl (
  input wire logic [7:0] dq_in,
  output logic [7:0] dq_out,
  input wire logic ce_n,
  input wire logic oe_n,
  input wire logic we_n,
  input wire logic unprot,
  input wire logic prot,
  input wire logic stuck,
  input wire logic [7:0] busy_rds
);
  logic [7:0] pv = 8'hff; // array byte at the target
  logic [7:0] last = 8'h00; // last byte driven out
  logic [15:0] rd_n = 16'h0000; // reads seen
  logic [15:0] goal = 16'h0000; // read count that ends the operation
  logic [2:0] cnt = 3'h0; // command cycles seen
  logic tog = 1'b0; // toggle state
  logic vfy = 1'b0; // verify mode
  logic pgm = 1'b0; // program armed
  logic busy; // embedded operation running
  logic [7:0] rd_v; // value on a read
  assign busy = (rd_n < goal) || stuck;
  assign rd_v = vfy ? {7'h00, prot & ~unprot} :
    busy ? {~pv[7], tog, stuck, pv[4:0]} : pv;
  // released pins show the inverse of the last byte
  assign dq_out = (!ce_n && !oe_n) ? rd_v : ~last;
  // toggle on each busy read
  // only a full low-then-high pulse counts, not the reset settle
  always @(negedge oe_n) begin
    @(posedge oe_n);
    last <= rd_v;
    rd_n <= rd_n + 16'h1;
    if (busy) tog <= ~tog;
  end
  // start after final cycle, unless locked
  always @(negedge we_n) begin
    @(posedge we_n);
    cnt <= cnt + 3'h1;
    if (dq_in == 8'hf0) begin
      cnt <= 3'h0;
      vfy <= 1'b0;
    end else if (pgm) begin
      pgm <= 1'b0;
      cnt <= 3'h0;
      if (!prot || unprot) begin
        pv <= dq_in;
        goal <= rd_n + {8'h00, busy_rds};
      end
    end else if (cnt == 3'h2 && dq_in == 8'ha0) pgm <= 1'b1;
    else if (cnt == 3'h2 && dq_in == 8'h90) vfy <= 1'b1;
    else if (cnt == 3'h5) begin
      cnt <= 3'h0;
      if (!prot || unprot) begin
        pv <= 8'hff;
        goal <= rd_n + {8'h00, busy_rds};
      end
    end
  end
endmodule // pfsp_flash_mdl
`default_nettype wire

// ### dv/parallel_flash_status_poll_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module parallel_flash_status_poll_tb_top;
  logic mclk, nrst, reg_we, reg_re, irq, prot, stuck;
  logic [7:0] reg_addr, dq_o, dq_i;
  logic [31:0] reg_wdata, reg_rdata;
  logic [18:0] faddr;
  logic oe, ce_n, oe_n, we_n, unp;
  int error_cnt = 0, num_checks = 0, cyc = 0, n;
  ///////////////////////////////////////////////////////////////////////
  pfsp_host i_dut (.mclk(mclk), .nrst(nrst), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_we(reg_we), .reg_re(reg_re),
    .reg_rdata(reg_rdata), .irq(irq), .flash_addr(faddr),
    .flash_dq_o(dq_o), .flash_dq_oe(oe), .flash_dq_i(dq_i),
    .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
    .flash_unprot(unp));
  pfsp_flash_mdl i_mdl (.dq_in(dq_o), .dq_out(dq_i), .ce_n(ce_n),
    .oe_n(oe_n), .we_n(we_n), .unprot(unp), .prot(prot),
    .stuck(stuck), .busy_rds(8'h03));
  ///////////////////////////////////////////////////////////////////////
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end
  task automatic complete_run;
    if (error_cnt == 0 && num_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  // hang guard
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      complete_run();
    end
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr <= a;
    reg_wdata <= d;
    reg_we <= 1'b1;
    @(posedge mclk);
    reg_we <= 1'b0;
    @(posedge mclk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] m,
    input logic [31:0] e);
    reg_addr <= a;
    reg_re <= 1'b1;
    @(posedge mclk);
    reg_re <= 1'b0;
    @(negedge mclk);
    chk(reg_rdata & m, e);
    @(posedge mclk);
  endtask
  // one full operation, then status and event check
  task automatic op(input logic [31:0] ctl, input logic [7:0] d,
    input logic [31:0] m, input logic [31:0] st, input logic [1:0] ev);
    wr(8'h08, {24'h0, d});
    wr(8'h04, 32'h0000_0123);
    wr(8'h00, ctl);
    for (n = 0; n < 3000 && irq !== 1'b1; n++) @(posedge mclk);
    chk({31'h0, irq}, 32'h0000_0001);
    rd(8'h0c, m, st);
    rd(8'h10, 32'h0000_0003, {30'h0, ev});
    wr(8'h10, 32'h0000_0003);
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({31'h0, irq}, 32'h0000_0000);
    @(posedge mclk);
  endtask
  ///////////////////////////////////////////////////////////////////////
  initial begin
    nrst = 1'b0;
    reg_we = 1'b0;
    reg_re = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0000_0000;
    prot = 1'b0;
    stuck = 1'b0;
    repeat (5) @(posedge mclk);
    nrst <= 1'b1;
    @(posedge mclk);
    rd(8'h00, 32'h0000_001f, 32'h0000_0000);
    rd(8'h14, 32'h0000_0003, 32'h0000_0000);
    rd(8'h18, 32'hffff_ffff, 32'h0000_0000);
    wr(8'h14, 32'h0000_0003);
    op(32'h0000_0001, 8'h5a, 32'h0000_ff07, 32'h0000_5a00, 2'h1);
    op(32'h0000_0009, 8'ha5, 32'h0000_ff07, 32'h0000_a500, 2'h1);
    op(32'h0000_000b, 8'h00, 32'h0000_ff07, 32'h0000_ff00, 2'h1);
    op(32'h0000_0005, 8'h00, 32'h0000_ff07, 32'h0000_ff00, 2'h1);
    stuck <= 1'b1;
    op(32'h0000_0001, 8'h81, 32'h0000_0007, 32'h0000_0002, 2'h3);
    op(32'h0000_0009, 8'h81, 32'h0000_0007, 32'h0000_0002, 2'h3);
    stuck <= 1'b0;
    op(32'h0000_0009, 8'h00, 32'h0000_ff07, 32'h0000_0000, 2'h1);
    prot <= 1'b1;
    op(32'h0000_0007, 8'h00, 32'h0000_ff07, 32'h0000_0104, 2'h1);
    op(32'h0000_0017, 8'h00, 32'h0000_ff07, 32'h0000_0000, 2'h1);
    wr(8'h00, 32'h0000_0000);
    op(32'h0000_0007, 8'h00, 32'h0000_ff07, 32'h0000_0104, 2'h1);
    wr(8'h14, 32'h0000_0000);
    repeat (3) @(posedge mclk);
    complete_run();
  end
endmodule // parallel_flash_status_poll_tb_top
`default_nettype wire
